// ===== core/fwid_defs.vh
`ifndef FWID_DEFS_VH
`define FWID_DEFS_VH
// Low address patterns of the identification read.
`define FWID_PAT_MAKER   4'h0
`define FWID_PAT_DEV1    4'h1
`define FWID_PAT_PROT    4'h2
`define FWID_PAT_IND     4'h3
`define FWID_PAT_DEV2    4'hE
`define FWID_PAT_DEV3    4'hF
// Indicator word fixed low bits.
`define FWID_IND_LOW     3'h1
// Command bytes and unlock addresses.
`define FWID_UNLK_A1     12'h555
`define FWID_UNLK_A2     12'h2AA
`define FWID_UNLK_D1     8'hAA
`define FWID_UNLK_D2     8'h55
`define FWID_CMD_ID      8'h90
`define FWID_CMD_BYP     8'h20
`define FWID_CMD_PROG    8'hA0
`define FWID_CMD_ERASE   8'h80
`define FWID_CMD_CFG     8'hD0
`define FWID_CMD_RESET   8'hF0
`define FWID_CMD_SECT    8'h30
`define FWID_CMD_CHIP    8'h10
// Idle levels of the filtered pins after reset: clock low, strobes high,
// boost at logic high, no high voltage and no id voltage present.
`define FWID_PIN_IDLE    8'h7C
// Width of the bank field at the top of the address.
`define FWID_BANK_W      3
`endif

// ===== core/fwid_core.v
`include "fwid_defs.vh"

// What this block does
// - Reset defaults to asynchronous reads; config command enables synchronous.
// - Asynchronous mode takes only asynchronous writes, clock ignored.
// - Synchronous mode takes asynchronous and clocked writes.
// - Clocked writes latch address on clock rise with address valid low.
// - Address on later falling edge, data first rising.
// - Programming ignores the read mode bit.
// - Bypass mode programs a word in two writes.
// - Erase sector, sector set, or whole device.
// - High boost voltage forces bypass; removal returns normal.
// - Boost input low locks every sector.
// - Identification reads return internal codes on sixteen bits.
// - Protection query returns one when sector protected.
// - Indicator word layout with fixed 001 low bits.
// - Identification reachable through command sequence too.
// - Bank-addressed identification; other banks return array data.
// - Identification only while in asynchronous read mode.
module fwid_core #(
   parameter AW        = 23,                 // Word address width.
   parameter SW        = 11,                 // Sector select bits width.
   parameter [15:0] MAKER_CODE = 16'h00A5,   // Arbitrary value.
   parameter [15:0] DEV_CODE1  = 16'h5A01,   // Arbitrary value.
   parameter [15:0] DEV_CODE2  = 16'h5A02,   // Arbitrary value.
   parameter [15:0] DEV_CODE3  = 16'h5A03    // Arbitrary value.
) (
   input  wire          core_clk_in,            // 100 MHz clock.
   input  wire          resetn_in,              // Async reset, active low.
   input  wire          flash_clk_in,           // Host burst clock pin.
   input  wire          chip_sel_n_in,          // Chip select pin, active low.
   input  wire          write_en_n_in,          // Write enable pin, active low.
   input  wire          out_en_n_in,            // Output enable pin, active low.
   input  wire          address_valid_n_in,     // Address valid pin, active low.
   input  wire [AW-1:0] addr_in,                // Address pins.
   input  wire [15:0]   data_in,                // Write data pins.
   input  wire          program_boost_input_in, // Boost pin at logic high.
   input  wire          high_program_voltage_in,// Boost pin at high voltage.
   input  wire          identification_voltage_in, // Id voltage on id line.
   input  wire [15:0]   array_data_in,          // Array read word.
   input  wire          sector_prot_in,         // Addressed sector protected.
   input  wire [7:0]    indicator_in,           // Locks, handshake, boot code.
   output reg  [15:0]   read_data_out,          // Read word to the pins.
   output reg           sync_read_out,          // Synchronous read mode.
   output reg           bypass_out,             // Fast program bypass mode.
   output reg           id_mode_out,            // Identification mode active.
   output reg  [2:0]    id_bank_out,            // Bank that shows id data.
   output reg           prog_req_out,           // Program request pulse.
   output reg  [AW-1:0] op_addr_out,            // Program or erase address.
   output reg  [15:0]   op_data_out,            // Program data.
   output reg           erase_req_out,          // Erase request pulse.
   output reg  [1:0]    erase_kind_out,         // 0 sector, 1 add sector, 2 chip.
   output reg           all_locked_out          // Every sector locked.
);

   // Reset release through two flip-flops.
   reg  rst_a_reg;
   reg  rst_b_reg;
   wire rst_n = rst_b_reg;

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_a_reg <= 1'b0;
         rst_b_reg <= 1'b0;
      end else begin
         rst_a_reg <= 1'b1;
         rst_b_reg <= rst_a_reg;
      end
   end

   // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree.
   localparam NP = 8;
   wire [NP-1:0] pin_raw = {flash_clk_in, chip_sel_n_in, write_en_n_in, out_en_n_in,
                            address_valid_n_in, program_boost_input_in,
                            high_program_voltage_in, identification_voltage_in};
   reg  [NP-1:0] s1_reg;
   reg  [NP-1:0] s2_reg;
   reg  [NP-1:0] s3_reg;
   reg  [NP-1:0] pin_reg;   // Filtered pin levels.
   reg  [NP-1:0] pin_next;
   integer i;

   always @* begin
      pin_next = pin_reg;
      for (i = 0; i < NP; i = i + 1) begin
         if (s2_reg[i] == s3_reg[i]) begin
            pin_next[i] = s3_reg[i];
         end
      end
   end

   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg  <= `FWID_PIN_IDLE;
         s2_reg  <= `FWID_PIN_IDLE;
         s3_reg  <= `FWID_PIN_IDLE;
         pin_reg <= `FWID_PIN_IDLE;
      end else begin
         s1_reg  <= pin_raw;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         pin_reg <= pin_next;
      end
   end

   wire clk_p  = pin_reg[7];
   wire ce_n   = pin_reg[6];
   wire we_n   = pin_reg[5];
   wire oe_n   = pin_reg[4];
   wire avd_n  = pin_reg[3];
   wire acc_hi = pin_reg[2];
   wire high_program_voltage    = pin_reg[1];
   wire identification_voltage    = pin_reg[0];

   // Address and data follow the filtered strobes, so they are settled by then.
   reg  ce_d_reg;
   reg  we_d_reg;
   reg  clk_d_reg;
   reg  [AW-1:0] lat_addr_reg;
   wire both_low   = !ce_n && !we_n;
   wire was_both   = !ce_d_reg && !we_d_reg;
   wire async_addr = both_low && !was_both && oe_n;
   wire rise_data  = was_both && (ce_n || we_n);
   wire clk_rise   = clk_p && !clk_d_reg;
   // Clocked address latch only counts when synchronous reads are set.
   wire sync_addr  = sync_read_out && clk_rise && !avd_n && !ce_n && oe_n;
   wire [AW-1:0] wr_addr = lat_addr_reg;

   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ce_d_reg     <= 1'b1;
         we_d_reg     <= 1'b1;
         clk_d_reg    <= 1'b0;
         lat_addr_reg <= {AW{1'b0}};
      end else begin
         ce_d_reg  <= ce_n;
         we_d_reg  <= we_n;
         clk_d_reg <= clk_p;
         if (async_addr || sync_addr) begin
            lat_addr_reg <= addr_in;
         end
      end
   end

   // Command state machine.
   localparam ST_IDLE = 3'h0;
   localparam ST_U1   = 3'h1;
   localparam ST_U2   = 3'h2;
   localparam ST_PROG = 3'h3;
   localparam ST_E1   = 3'h4;
   localparam ST_E2   = 3'h5;
   localparam ST_E3   = 3'h6;
   localparam ST_ESEQ = 3'h7;
   reg [2:0] st_reg;
   reg       byp_cmd_reg;   // Bypass entered by command.

   function is_unlock;
      input [11:0] a;
      input [7:0]  d;
      input [11:0] ea;
      input [7:0]  ed;
      is_unlock = (a == ea) && (d == ed);
   endfunction

   wire [11:0] la = wr_addr[11:0];
   wire [7:0]  ld = data_in[7:0];
   wire        byp = byp_cmd_reg || high_program_voltage;

   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_reg         <= ST_IDLE;
         byp_cmd_reg    <= 1'b0;
         sync_read_out  <= 1'b0;
         id_mode_out    <= 1'b0;
         id_bank_out    <= 3'h0;
         prog_req_out   <= 1'b0;
         erase_req_out  <= 1'b0;
         erase_kind_out <= 2'h0;
         op_addr_out    <= {AW{1'b0}};
         op_data_out    <= 16'h0000;
         bypass_out     <= 1'b0;
         all_locked_out <= 1'b1;
      end else begin
         prog_req_out   <= 1'b0;
         erase_req_out  <= 1'b0;
         bypass_out     <= byp;
         all_locked_out <= !acc_hi;
         if (rise_data) begin
            // Write handling ignores the read mode bit, except the id command, taken only in asynchronous mode.
            case (st_reg)
               ST_IDLE: begin
                  if (byp && ld == `FWID_CMD_PROG) begin
                     st_reg <= ST_PROG;
                  end else if (byp_cmd_reg && ld == `FWID_CMD_ID) begin
                     byp_cmd_reg <= 1'b0;                // Bypass exit in a single write.
                  end else if (ld == `FWID_CMD_RESET) begin
                     id_mode_out <= 1'b0;
                     byp_cmd_reg <= 1'b0;
                  end else if (is_unlock(la, ld, `FWID_UNLK_A1, `FWID_UNLK_D1)) begin
                     st_reg <= ST_U1;
                  end
               end
               ST_U1: begin
                  st_reg <= is_unlock(la, ld, `FWID_UNLK_A2, `FWID_UNLK_D2) ? ST_U2 : ST_IDLE;
               end
               ST_U2: begin
                  st_reg <= ST_IDLE;
                  if (ld == `FWID_CMD_ID && !sync_read_out) begin
                     id_mode_out <= 1'b1;
                     id_bank_out <= wr_addr[AW-1:AW-3];
                  end else if (ld == `FWID_CMD_PROG) begin
                     st_reg <= ST_PROG;
                  end else if (ld == `FWID_CMD_BYP) begin
                     byp_cmd_reg <= 1'b1;
                  end else if (ld == `FWID_CMD_CFG) begin
                     sync_read_out <= 1'b1;
                     id_mode_out   <= 1'b0;
                  end else if (ld == `FWID_CMD_ERASE) begin
                     st_reg <= ST_E1;
                  end
               end
               ST_PROG: begin
                  st_reg       <= ST_IDLE;
                  prog_req_out <= acc_hi;
                  op_addr_out  <= wr_addr;
                  op_data_out  <= data_in;
               end
               ST_E1: begin
                  st_reg <= is_unlock(la, ld, `FWID_UNLK_A1, `FWID_UNLK_D1) ? ST_E2 : ST_IDLE;
               end
               ST_E2: begin
                  st_reg <= is_unlock(la, ld, `FWID_UNLK_A2, `FWID_UNLK_D2) ? ST_E3 : ST_IDLE;
               end
               ST_E3, ST_ESEQ: begin
                  // Chip erase, or sector erase; more sector writes add sectors.
                  if (ld == `FWID_CMD_CHIP && st_reg == ST_E3) begin
                     st_reg         <= ST_IDLE;
                     erase_req_out  <= acc_hi;
                     erase_kind_out <= 2'h2;
                  end else if (ld == `FWID_CMD_SECT) begin
                     st_reg         <= ST_ESEQ;
                     erase_req_out  <= acc_hi;
                     erase_kind_out <= (st_reg == ST_ESEQ) ? 2'h1 : 2'h0;
                     op_addr_out    <= {wr_addr[AW-1:AW-SW], {(AW-SW){1'b0}}};
                  end else begin
                     st_reg <= ST_IDLE;
                  end
               end
               default: st_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // Read data: id codes in id mode for the chosen bank, or via id voltage.
   wire [3:0] pat    = addr_in[3:0];
   wire       id_sel = (identification_voltage && !sync_read_out) ||
                       (id_mode_out && addr_in[AW-1:AW-3] == id_bank_out);
   reg  [15:0] id_word;

   always @* begin
      case (pat)
         `FWID_PAT_MAKER: id_word = MAKER_CODE;
         `FWID_PAT_DEV1:  id_word = DEV_CODE1;
         `FWID_PAT_DEV2:  id_word = DEV_CODE2;
         `FWID_PAT_DEV3:  id_word = DEV_CODE3;
         `FWID_PAT_PROT:  id_word = {15'h0000, sector_prot_in};
         `FWID_PAT_IND:   id_word = {8'h00, indicator_in[7:3], `FWID_IND_LOW};
         default:         id_word = 16'h0000;
      endcase
   end

   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         read_data_out <= 16'h0000;
      end else begin
         read_data_out <= id_sel ? id_word : array_data_in;
      end
   end

endmodule

// ===== dv/fwid_core_chk.sv
module fwid_core_chk #(
   parameter        AW         = 23,
   parameter [15:0] MAKER_CODE = 16'h0000
) (
   input wire          core_clk_in,
   input wire          resetn_in,
   input wire [AW-1:0] addr_in,
   input wire          program_boost_input_in,
   input wire          high_program_voltage_in,
   input wire          identification_voltage_in,
   input wire [15:0]   array_data_in,
   input wire [7:0]    indicator_in,
   input wire [15:0]   read_data_out,
   input wire          sync_read_out,
   input wire          bypass_out,
   input wire          id_mode_out,
   input wire [2:0]    id_bank_out,
   input wire          prog_req_out,
   input wire          erase_req_out,
   input wire          all_locked_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // A read aimed at the bank that shows the codes, voltage path idle.
   wire hit = id_mode_out && !identification_voltage_in && addr_in[AW-1:AW-3] == id_bank_out;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   a_reset_async_mode: assert property ($rose(resetn_in) |-> !sync_read_out && !id_mode_out)
      else $error("modes not cleared by reset");
   a_sync_sticky: assert property (sync_read_out |=> sync_read_out)
      else $error("sync mode dropped");
   a_boost_low_lock: assert property (!program_boost_input_in [*8] |-> all_locked_out)
      else $error("boost low but not locked");
   a_locked_no_op: assert property (!program_boost_input_in [*8] |-> !prog_req_out && !erase_req_out)
      else $error("operation while locked");
   a_hv_bypass: assert property (high_program_voltage_in [*8] |-> bypass_out)
      else $error("high voltage without bypass");
   a_id_async_only: assert property ($rose(id_mode_out) |-> !sync_read_out)
      else $error("id mode entered in sync mode");
   a_id_maker_word: assert property (hit && addr_in[3:0] == 4'h0 ##1 id_mode_out |-> read_data_out == MAKER_CODE)
      else $error("maker word wrong");
   a_id_indic_word: assert property (hit && addr_in[3:0] == 4'h3 ##1 id_mode_out
      |-> read_data_out == {8'h00, $past(indicator_in[7:3]), 3'h1})
      else $error("indicator word wrong");
   a_other_bank: assert property (id_mode_out && !hit && !identification_voltage_in ##1 id_mode_out
      |-> read_data_out == $past(array_data_in))
      else $error("other bank not array data");
endmodule

bind fwid_core fwid_core_chk #(.AW(AW), .MAKER_CODE(MAKER_CODE)) u_fwid_core_chk (
   .core_clk_in, .resetn_in, .addr_in, .program_boost_input_in, .high_program_voltage_in,
   .identification_voltage_in, .array_data_in, .indicator_in, .read_data_out, .sync_read_out,
   .bypass_out, .id_mode_out, .id_bank_out, .prog_req_out, .erase_req_out, .all_locked_out);

// ===== dv/fwid_host.sv
module fwid_host (
   input  wire logic   clk_in,    // Core clock.
   output logic        fclk_out,  // Burst clock, still outside frames.
   output logic        ce_n_out,  // Chip select.
   output logic        we_n_out,  // Write enable.
   output logic        oe_n_out,  // Output enable.
   output logic        avd_n_out, // Address valid.
   output logic [22:0] addr_out,  // Address.
   output logic [15:0] data_out   // Write data.
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {fclk_out, ce_n_out, we_n_out, oe_n_out, avd_n_out} = 5'h0F;
   initial {addr_out, data_out} = 39'h0;
   // One write; the synchronised pins need several cycles per phase.
   task automatic wr(input logic [22:0] a, input logic [15:0] d, input logic s);
      @(posedge clk_in);
      {ce_n_out, oe_n_out} <= 2'h3;
      repeat (5) @(posedge clk_in);
      addr_out <= a;
      ce_n_out <= 1'b0;
      if (s) begin // Address phase: valid and select low, output off.
         avd_n_out <= 1'b0;
         repeat (6) @(posedge clk_in);
         fclk_out <= 1'b1;
         repeat (6) @(posedge clk_in);
         {fclk_out, avd_n_out} <= 2'h1;
      end
      data_out <= d;
      we_n_out <= 1'b0; // Select and write low, output off.
      repeat (8) @(posedge clk_in);
      {we_n_out, ce_n_out} <= 2'h3;
      repeat (8) @(posedge clk_in);
      data_out <= ~d; // A released bus must not show the old word.
      repeat (4) @(posedge clk_in);
   endtask
   // Read: the design answers from the address one cycle later.
   task automatic rd(input logic [22:0] a);
      @(posedge clk_in);
      addr_out <= a;
      {ce_n_out, oe_n_out} <= 2'h0;
      repeat (3) @(posedge clk_in);
   endtask
endmodule

// ===== dv/test_fwid_core.sv
module test_fwid_core;
   timeunit 1ns;
   timeprecision 100ps;
   localparam [15:0] MK = 16'h0C3A; // Arbitrary id codes.
   localparam [15:0] D1 = 16'h0C41;
   localparam [15:0] D2 = 16'h0C42;
   localparam [15:0] D3 = 16'h0C43;
   logic        clk = 1'b0, rst_n = 1'b0, boost = 1'b1, hv = 1'b0, idv = 1'b0, prot = 1'b1;
   logic        fclk, ce_n, we_n, oe_n, avd_n, sync, byp, idm, preq, ereq, lock;
   logic [22:0] addr, op_a, la;
   logic [15:0] data, rdd, op_d, ld;
   logic [2:0]  bank;
   logic [1:0]  ek, lk;
   int          n_prog = 0, n_era = 0, cyc = 0, err_count = 0, n_checks = 0;
   // Rows: low address pattern beside the word it must return.
   logic [19:0] rows [6] = '{{4'h0, MK}, {4'h1, D1}, {4'hE, D2}, {4'hF, D3},
                             {4'h2, 16'h0001}, {4'h3, 16'h00A9}};
   fwid_host u_fwid_host (.clk_in(clk), .fclk_out(fclk), .ce_n_out(ce_n), .we_n_out(we_n),
      .oe_n_out(oe_n), .avd_n_out(avd_n), .addr_out(addr), .data_out(data));
   fwid_core #(.MAKER_CODE(MK), .DEV_CODE1(D1), .DEV_CODE2(D2), .DEV_CODE3(D3)) u_fwid_core (
      .core_clk_in(clk), .resetn_in(rst_n), .flash_clk_in(fclk), .chip_sel_n_in(ce_n),
      .write_en_n_in(we_n), .out_en_n_in(oe_n), .address_valid_n_in(avd_n), .addr_in(addr),
      .data_in(data), .program_boost_input_in(boost), .high_program_voltage_in(hv),
      .identification_voltage_in(idv), .array_data_in(16'h3C5A), .sector_prot_in(prot),
      .indicator_in(8'hA8), .read_data_out(rdd), .sync_read_out(sync), .bypass_out(byp),
      .id_mode_out(idm), .id_bank_out(bank), .prog_req_out(preq), .op_addr_out(op_a),
      .op_data_out(op_d), .erase_req_out(ereq), .erase_kind_out(ek), .all_locked_out(lock));
   always #5 clk = ~clk;
   // Pulses last one cycle, so they are counted here as they pass.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
      if (preq === 1'b1) begin
         n_prog <= n_prog + 1;
         {la, ld} <= {op_a, op_d};
      end
      if (ereq === 1'b1) begin
         n_era <= n_era + 1;
         lk <= ek;
      end
   end
   task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
      #1;
      n_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic cmd(input logic [2:0] b, input logic [7:0] c, input logic s);
      u_fwid_host.wr(23'h000555, 16'h00AA, s);
      u_fwid_host.wr(23'h0002AA, 16'h0055, s);
      u_fwid_host.wr({b, 8'h00, 12'h555}, {8'h00, c}, s);
   endtask
   task automatic rst();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   // Boost, high voltage and id voltage pins, then time for the synchronisers.
   task automatic pins(input logic b, input logic h, input logic v);
      @(posedge clk);
      {boost, hv, idv} <= {b, h, v};
      repeat (10) @(posedge clk);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      rst();
      chk("sync", 0, sync);
      cmd(3'h3, 8'h90, 1'b0);
      chk("idm", 1, idm);
      chk("bank", 3, bank);
      foreach (rows[i]) begin
         u_fwid_host.rd({3'h3, 16'h0000, rows[i][19:16]});
         chk("idword", rows[i][15:0], rdd);
      end
      @(posedge clk) prot <= 1'b0;
      u_fwid_host.rd({3'h3, 16'h0000, 4'h2});
      chk("unprot", 16'h0000, rdd);
      u_fwid_host.rd(23'h500000);
      chk("other", 16'h3C5A, rdd);
      u_fwid_host.wr(23'h000000, 16'h00F0, 1'b0); // Reset is a single write.
      chk("idexit", 0, idm);
      cmd(3'h0, 8'hA0, 1'b0);
      u_fwid_host.wr(23'h012345, 16'hBEEF, 1'b0);
      chk("addr", 23'h012345, la);
      chk("data", 16'hBEEF, ld);
      cmd(3'h0, 8'h20, 1'b0);
      chk("byp", 1, byp);
      u_fwid_host.wr(23'h000000, 16'h00A0, 1'b0);
      u_fwid_host.wr(23'h000777, 16'h1357, 1'b0);
      chk("nprog", 2, 23'(n_prog));
      u_fwid_host.wr(23'h000000, 16'h0090, 1'b0);
      chk("bypx", 0, byp);
      pins(1'b1, 1'b1, 1'b0); // Boost already at logic high, sectors unlocked.
      chk("hvb", 1, byp);
      pins(1'b1, 1'b0, 1'b0);
      chk("hvx", 0, byp);
      pins(1'b0, 1'b0, 1'b0);
      chk("lock", 1, lock);
      cmd(3'h0, 8'hA0, 1'b0);
      u_fwid_host.wr(23'h000100, 16'h0F0F, 1'b0);
      chk("nlock", 2, 23'(n_prog));
      pins(1'b1, 1'b0, 1'b0);
      cmd(3'h0, 8'h80, 1'b0);
      cmd(3'h2, 8'h30, 1'b0);
      chk("sect", 0, lk);
      u_fwid_host.wr(23'h100000, 16'h0030, 1'b0);
      chk("addsect", 1, lk);
      u_fwid_host.wr(23'h000000, 16'h00F0, 1'b0); // Ends the sector list.
      cmd(3'h0, 8'h80, 1'b0);
      cmd(3'h0, 8'h10, 1'b0);
      chk("chip", 2, lk);
      chk("nera", 3, 23'(n_era));
      pins(1'b1, 1'b0, 1'b1); // Id voltage with maker pattern on the low lines.
      u_fwid_host.rd(23'h000000);
      chk("idv", MK, rdd);
      pins(1'b1, 1'b0, 1'b0);
      cmd(3'h0, 8'hD0, 1'b0);
      chk("sync", 1, sync);
      cmd(3'h3, 8'h90, 1'b1);
      chk("idsync", 0, idm);
      cmd(3'h0, 8'hA0, 1'b1);
      u_fwid_host.wr(23'h000ABC, 16'h2468, 1'b1);
      chk("caddr", 23'h000ABC, la);
      chk("cdata", 16'h2468, ld);
      rst();
      chk("sync", 0, sync);
      results();
   end
endmodule
